/* rtl/sensor_mode_pkg.sv */
// constants, enumerations and timing counts for the sensor channel mode control
package sensor_mode_pkg;
  localparam int CHANNELS       = 2;
  localparam int CLK_HZ         = 40_000_000;
  localparam int CLK_NS         = 25;
  // sync pulse widths, least times, so rounded up to whole cycles
  localparam int SYNC_SHORT_NS  = 3000;
  localparam int SYNC_LONG_NS   = 6000;
  localparam int SYNC_SHORT_CYC = (SYNC_SHORT_NS + CLK_NS - 1) / CLK_NS;
  localparam int SYNC_LONG_CYC  = (SYNC_LONG_NS + CLK_NS - 1) / CLK_NS;
  // automatic trigger period of the internal timer
  localparam int SYNC_PERIOD_US = 500;
  localparam int SYNC_PERIOD_CYC = SYNC_PERIOD_US * (CLK_HZ / 1_000_000);
  // line bit rate and frame length
  localparam int BIT_RATE_BPS   = 125_000;
  localparam int BIT_CYC        = CLK_HZ / BIT_RATE_BPS;
  localparam int FRAME_BITS     = 10;

  typedef enum logic [2:0] {
    OP_ENABLE,
    OP_TRIG_SRC,
    OP_DL_METHOD,
    OP_SPI_TRIG,
    OP_DL_BIT
  } cmd_op_t;

  typedef enum logic [1:0] {
    SRC_NONE,
    SRC_SPI,
    SRC_PIN,
    SRC_TIMER
  } trig_src_t;

  typedef enum logic [0:0] {
    DEC_IDLE,
    DEC_BITS
  } dec_st_t;
endpackage

/* rtl/sensor_channel_mode_control.sv */
// two-channel sensor line mode, trigger and downlink control
`timescale 1ns/1ps
module sensor_channel_mode_control
  import sensor_mode_pkg::*;
#(
  parameter int SYNC_PERIOD = SYNC_PERIOD_CYC,
  parameter int FB          = FRAME_BITS
) (
  input  wire logic                         CLOCK,
  input  wire logic                         RESET,
  input  wire logic                         MODE_SEL,
  input  wire logic                         CMD_VALID,
  input  wire logic                         CMD_CHAN,
  input  cmd_op_t                           CMD_OP,
  input  wire logic [1:0]                   CMD_DATA,
  input  wire logic [CHANNELS-1:0]          SYNC_PIN,
  input  wire logic [CHANNELS-1:0]          RX_LINE,
  input  wire logic [CHANNELS-1:0]          FRAME_READ,
  output logic      [CHANNELS-1:0]          CHAN_ACTIVE,
  output logic      [CHANNELS-1:0]          SYNC_SUPPLY_EN,
  output logic      [CHANNELS-1:0]          SYNC_PULSE,
  output logic      [CHANNELS-1:0]          DOUT,
  output logic      [CHANNELS-1:0]          FRAME_VALID,
  output logic      [CHANNELS-1:0]          FRAME_OVERRUN,
  output logic      [CHANNELS-1:0][FB-1:0]  FRAME_DATA
);
  localparam int TW = $clog2(SYNC_PERIOD);
  localparam int PW = $clog2(SYNC_LONG_CYC);
  localparam int BW = $clog2(BIT_CYC);
  localparam int NW = $clog2(FB);
  localparam logic [TW-1:0] TMR_LAST  = TW'(SYNC_PERIOD - 1);
  localparam logic [PW-1:0] SHORT_LEN = PW'(SYNC_SHORT_CYC - 1);
  localparam logic [PW-1:0] LONG_LEN  = PW'(SYNC_LONG_CYC - 1);
  localparam logic [BW-1:0] BIT_LAST  = BW'(BIT_CYC - 1);
  localparam logic [BW-1:0] BIT_HALF  = BW'(BIT_CYC / 2);
  localparam logic [NW-1:0] FB_LAST   = NW'(FB - 1);

  typedef struct packed {
    logic      [CHANNELS-1:0]          en;
    trig_src_t [CHANNELS-1:0]          src;
    logic      [CHANNELS-1:0]          dl_mask;
    logic      [CHANNELS-1:0]          dl_pend;
    logic      [CHANNELS-1:0]          dl_bit;
    logic      [CHANNELS-1:0][2:0]     pin_s;
    logic      [CHANNELS-1:0][2:0]     rx_s;
    logic      [CHANNELS-1:0][TW-1:0]  tmr;
    logic      [CHANNELS-1:0][PW-1:0]  pcnt;
    logic      [CHANNELS-1:0]          pulse;
    logic      [CHANNELS-1:0]          supply;
    dec_st_t   [CHANNELS-1:0]          dst;
    logic      [CHANNELS-1:0][BW-1:0]  bcnt;
    logic      [CHANNELS-1:0][BW-1:0]  h1;
    logic      [CHANNELS-1:0][BW-1:0]  h2;
    logic      [CHANNELS-1:0][NW-1:0]  nbits;
    logic      [CHANNELS-1:0][FB-1:0]  shf;
    logic      [CHANNELS-1:0][FB-1:0]  fdata;
    logic      [CHANNELS-1:0]          fval;
    logic      [CHANNELS-1:0]          ovr;
    logic      [CHANNELS-1:0]          dout;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  always_comb begin
    logic trig;
    logic rx;
    logic bitv;
    logic [BW-1:0] h1v;
    logic [BW-1:0] h2v;
    trig = 1'b0;
    rx = 1'b0;
    bitv = 1'b0;
    h1v = '0;
    h2v = '0;
    state_nxt = state_r;
    for (int c = 0; c < CHANNELS; c++) begin
      trig = 1'b0;
      // first stage feeds only the second; logic reads stage two and three
      state_nxt.rx_s[c] = {state_r.rx_s[c][1:0], RX_LINE[c]};
      state_nxt.pin_s[c] = {state_r.pin_s[c][1:0], SYNC_PIN[c]};
      rx = state_r.rx_s[c][2];
      // per-channel settings, one command addresses one channel only
      if (CMD_VALID && (CMD_CHAN == 1'(c))) begin
        case (CMD_OP)
          OP_ENABLE:    state_nxt.en[c] = CMD_DATA[0];
          OP_TRIG_SRC:  state_nxt.src[c] = trig_src_t'(CMD_DATA);
          OP_DL_METHOD: state_nxt.dl_mask[c] = CMD_DATA[0];
          OP_SPI_TRIG:  trig = (state_r.src[c] == SRC_SPI);
          OP_DL_BIT: begin
            state_nxt.dl_bit[c] = CMD_DATA[0];
            state_nxt.dl_pend[c] = 1'b1;
          end
          default: ;
        endcase
      end
      if (state_r.src[c] == SRC_PIN && state_r.pin_s[c][1] && !state_r.pin_s[c][2]) begin
        trig = 1'b1;
      end
      // timer runs only while it is the chosen source, so it restarts cleanly
      if (state_r.en[c] && state_r.src[c] == SRC_TIMER) begin
        state_nxt.tmr[c] = (state_r.tmr[c] == TMR_LAST) ? '0 : state_r.tmr[c] + 1'b1;
        trig = trig | (state_r.tmr[c] == TMR_LAST);
      end else begin
        state_nxt.tmr[c] = '0;
      end
      state_nxt.supply[c] = state_r.en[c] && (state_r.src[c] != SRC_NONE);
      // triggers during a running pulse are dropped
      if (state_r.pulse[c]) begin
        if (state_r.pcnt[c] == '0) state_nxt.pulse[c] = 1'b0;
        else state_nxt.pcnt[c] = state_r.pcnt[c] - 1'b1;
      end else if (trig && state_r.supply[c]) begin
        state_nxt.dl_pend[c] = 1'b0;
        if (!state_r.dl_pend[c]) begin
          state_nxt.pulse[c] = 1'b1;
          state_nxt.pcnt[c] = SHORT_LEN;
        end else if (state_r.dl_mask[c]) begin
          state_nxt.pulse[c] = !state_r.dl_bit[c];
          state_nxt.pcnt[c] = SHORT_LEN;
        end else begin
          state_nxt.pulse[c] = 1'b1;
          state_nxt.pcnt[c] = state_r.dl_bit[c] ? LONG_LEN : SHORT_LEN;
        end
      end
      if (!state_r.en[c]) state_nxt.pulse[c] = 1'b0;
      // raw mode: line bits straight out, host does all checking
      state_nxt.dout[c] = MODE_SEL && state_r.en[c] && rx;
      // host read clears first so a frame landing in the same cycle wins
      if (FRAME_READ[c]) begin
        state_nxt.fval[c] = 1'b0;
        state_nxt.ovr[c] = 1'b0;
      end
      if (!MODE_SEL && state_r.en[c]) begin
        case (state_r.dst[c])
          DEC_IDLE: begin
            if (rx) begin
              state_nxt.dst[c] = DEC_BITS;
              state_nxt.bcnt[c] = '0;
              state_nxt.h1[c] = '0;
              state_nxt.h2[c] = '0;
              state_nxt.nbits[c] = '0;
            end
          end
          DEC_BITS: begin
            // half-bit majority vote tolerates duty distortion of the line
            h1v = state_r.h1[c] + BW'(rx && state_r.bcnt[c] < BIT_HALF);
            h2v = state_r.h2[c] + BW'(rx && state_r.bcnt[c] >= BIT_HALF);
            state_nxt.h1[c] = h1v;
            state_nxt.h2[c] = h2v;
            state_nxt.bcnt[c] = state_r.bcnt[c] + 1'b1;
            if (state_r.bcnt[c] == BIT_LAST) begin
              bitv = (h2v > h1v);
              state_nxt.shf[c] = {state_r.shf[c][FB-2:0], bitv};
              state_nxt.bcnt[c] = '0;
              state_nxt.h1[c] = '0;
              state_nxt.h2[c] = '0;
              state_nxt.nbits[c] = state_r.nbits[c] + 1'b1;
              if (state_r.nbits[c] == FB_LAST) begin
                state_nxt.fdata[c] = {state_r.shf[c][FB-2:0], bitv};
                state_nxt.fval[c] = 1'b1;
                state_nxt.ovr[c] = state_r.fval[c] && !FRAME_READ[c];
                state_nxt.dst[c] = DEC_IDLE;
              end
            end
          end
          default: state_nxt.dst[c] = DEC_IDLE;
        endcase
      end else begin
        state_nxt.dst[c] = DEC_IDLE;
      end
    end
  end

  always_ff @(posedge CLOCK) begin
    if (RESET) begin
      state_r <= '0;
    end else begin
      state_r <= state_nxt;
    end
  end

  assign CHAN_ACTIVE    = state_r.en;
  assign SYNC_SUPPLY_EN = state_r.supply;
  assign SYNC_PULSE     = state_r.pulse;
  assign DOUT           = state_r.dout;
  assign FRAME_VALID    = state_r.fval;
  assign FRAME_OVERRUN  = state_r.ovr;
  assign FRAME_DATA     = state_r.fdata;

  default clocking dc @(posedge CLOCK); endclocking
  default disable iff (RESET);

  AST_RESET_OFF: assert property ($fell(RESET) |-> CHAN_ACTIVE == '0)
    else $error("channel active right after reset");
  AST_ENABLE_CMD: assert property (CMD_VALID && CMD_OP == OP_ENABLE
    |=> CHAN_ACTIVE[$past(CMD_CHAN)] == $past(CMD_DATA[0]))
    else $error("enable command not applied");

  for (genvar g = 0; g < CHANNELS; g++) begin : g_chk
    logic [PW:0] hc_r;
    always_ff @(posedge CLOCK) begin
      if (RESET) hc_r <= '0;
      else hc_r <= SYNC_PULSE[g] ? hc_r + 1'b1 : '0;
    end
    sequence spi_trig_s;
      CMD_VALID && CMD_CHAN == 1'(g) && CMD_OP == OP_SPI_TRIG && state_r.src[g] == SRC_SPI;
    endsequence
    sequence idle_ready_s;
      !state_r.pulse[g] && state_r.supply[g] && state_r.en[g];
    endsequence
    AST_PULSE_LEN: assert property ($fell(SYNC_PULSE[g])
      |-> hc_r == (PW+1)'(SYNC_SHORT_CYC) || hc_r == (PW+1)'(SYNC_LONG_CYC))
      else $error("sync pulse width wrong");
    AST_SPI_TRIG: assert property (spi_trig_s and idle_ready_s and !state_r.dl_pend[g]
      |=> SYNC_PULSE[g] ##1 SYNC_PULSE[g])
      else $error("command trigger gave no pulse");
    AST_MASKED: assert property (spi_trig_s and idle_ready_s
      and (state_r.dl_pend[g] && state_r.dl_mask[g] && state_r.dl_bit[g])
      |=> !SYNC_PULSE[g] && !state_r.dl_pend[g])
      else $error("masked pulse was sent");
    AST_SUPPLY: assert property (SYNC_PULSE[g] |-> SYNC_SUPPLY_EN[g] && CHAN_ACTIVE[g])
      else $error("pulse without supply");
    AST_RAW_PASS: assert property ((MODE_SEL && CHAN_ACTIVE[g])[*5]
      |-> DOUT[g] == $past(RX_LINE[g], 4))
      else $error("raw bitstream not passed");
    AST_MODE1_QUIET: assert property (!MODE_SEL |=> !DOUT[g])
      else $error("direct pin active in decode mode");
    AST_FRAME_MODE: assert property ($rose(FRAME_VALID[g]) |-> !$past(MODE_SEL))
      else $error("frame stored in raw mode");
    AST_OFF_NO_PULSE: assert property (!CHAN_ACTIVE[g] |=> !SYNC_PULSE[g])
      else $error("disabled channel pulsed");
  end
endmodule

/* sim/sensor_line_model.sv */
// sensor side model: Manchester frames on the received line, idle low
`timescale 1ns/1ps
module sensor_line_model
  import sensor_mode_pkg::*;
(
  input  wire logic                CLOCK,
  output logic      [CHANNELS-1:0] RX_LINE
);
  initial RX_LINE = '0;
  // a zero bit is high then low, so frames start with a zero to line up with the start edge
  task automatic send(input int ch, input logic [FRAME_BITS-1:0] d);
    for (int i = FRAME_BITS - 1; i >= 0; i--) begin
      for (int h = 0; h < 2; h++) begin
        @(negedge CLOCK);
        RX_LINE[ch] = (h == 1) ? d[i] : ~d[i];
        repeat (BIT_CYC / 2 - 1) @(negedge CLOCK);
      end
    end
    @(negedge CLOCK);
    RX_LINE[ch] = 1'b0;
  endtask
endmodule

/* sim/tb_top.sv */
// self-checking bench for the sensor channel mode control
`timescale 1ns/1ps
module tb_top
  import sensor_mode_pkg::*;
;
  logic                         CLOCK = 0, RESET = 1, MODE_SEL = 0, CMD_VALID = 0, CMD_CHAN = 0;
  cmd_op_t                      cmd_op = OP_ENABLE;
  logic [1:0]                   CMD_DATA = '0, SYNC_PIN = '0, FRAME_READ = '0;
  logic [1:0]                   RX_LINE, CHAN_ACTIVE, SYNC_SUPPLY_EN, SYNC_PULSE, DOUT;
  logic [1:0]                   FRAME_VALID, FRAME_OVERRUN;
  logic [1:0][FRAME_BITS-1:0]   FRAME_DATA;
  logic [3:0]                   hist = '0;
  logic                         watch = 0;
  int                           err_count = 0, total_checks = 0, cyc = 0, w;
  always #12.5 CLOCK = ~CLOCK;
  sensor_channel_mode_control #(.SYNC_PERIOD(50), .FB(FRAME_BITS)) dut_u (
    .CLOCK(CLOCK), .RESET(RESET), .MODE_SEL(MODE_SEL), .CMD_VALID(CMD_VALID),
    .CMD_CHAN(CMD_CHAN), .CMD_OP(cmd_op), .CMD_DATA(CMD_DATA), .SYNC_PIN(SYNC_PIN),
    .RX_LINE(RX_LINE), .FRAME_READ(FRAME_READ), .CHAN_ACTIVE(CHAN_ACTIVE),
    .SYNC_SUPPLY_EN(SYNC_SUPPLY_EN), .SYNC_PULSE(SYNC_PULSE), .DOUT(DOUT),
    .FRAME_VALID(FRAME_VALID), .FRAME_OVERRUN(FRAME_OVERRUN), .FRAME_DATA(FRAME_DATA));
  sensor_line_model partner_u (.CLOCK(CLOCK), .RX_LINE(RX_LINE));
  task automatic final_report();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic chk_cnt(input int got, input int exp);
    chk(16'(got), 16'(exp));
  endtask
  // one command per call; the two idle negedges after each call keep strobes apart
  task automatic cmd(input logic ch, input cmd_op_t op, input logic [1:0] d);
    @(negedge CLOCK);
    CMD_VALID = 1;
    CMD_CHAN = ch;
    cmd_op = op;
    CMD_DATA = d;
    @(negedge CLOCK);
    CMD_VALID = 0;
    repeat (2) @(negedge CLOCK);
  endtask
  task automatic meas(input int ch, output int n);
    int t;
    n = 0;
    t = 0;
    while (SYNC_PULSE[ch] !== 1'b1 && t < 70) begin
      @(negedge CLOCK);
      t++;
    end
    while (SYNC_PULSE[ch] === 1'b1 && n < 400) begin
      @(negedge CLOCK);
      n++;
    end
  endtask
  // command trigger counted from the first negedge after the taking edge, where the pulse stands
  task automatic spi_pulse(input logic ch, output int n);
    @(negedge CLOCK);
    CMD_VALID = 1;
    CMD_CHAN = ch;
    cmd_op = OP_SPI_TRIG;
    CMD_DATA = 2'h0;
    @(negedge CLOCK);
    CMD_VALID = 0;
    meas(int'(ch), n);
  endtask
  always @(posedge CLOCK) begin
    hist <= {hist[2:0], RX_LINE[0]};
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      err_count++;
      final_report();
    end
  end
  // raw mode: delayed line copy; decode mode: output held low
  always @(negedge CLOCK)
    if (watch)
      chk(16'(DOUT), {15'h0, MODE_SEL & hist[3]});
  initial begin
    repeat (10) @(negedge CLOCK);
    RESET = 0;
    @(negedge CLOCK);
    chk(16'(CHAN_ACTIVE), 16'h0);
    chk(16'(SYNC_SUPPLY_EN), 16'h0);
    cmd(0, OP_ENABLE, 2'h1);
    chk(16'(CHAN_ACTIVE), 16'h1);
    chk(16'(SYNC_SUPPLY_EN), 16'h0);
    cmd(0, OP_TRIG_SRC, SRC_SPI);
    chk(16'(SYNC_SUPPLY_EN), 16'h1);
    spi_pulse(0, w);
    chk_cnt(w, SYNC_SHORT_CYC);
    $display("test spi trigger done");
    cmd(0, OP_DL_METHOD, 2'h0);
    cmd(0, OP_DL_BIT, 2'h1);
    spi_pulse(0, w);
    chk_cnt(w, SYNC_LONG_CYC);
    cmd(0, OP_DL_METHOD, 2'h1);
    cmd(0, OP_DL_BIT, 2'h1);
    spi_pulse(0, w);
    chk_cnt(w, 0);
    spi_pulse(0, w);
    chk_cnt(w, SYNC_SHORT_CYC);
    $display("test downlink done");
    cmd(1, OP_ENABLE, 2'h1);
    cmd(1, OP_TRIG_SRC, SRC_PIN);
    chk(16'(SYNC_SUPPLY_EN), 16'h3);
    SYNC_PIN[1] = 1;
    meas(1, w);
    SYNC_PIN[1] = 0;
    chk_cnt(w, SYNC_SHORT_CYC);
    cmd(0, OP_TRIG_SRC, SRC_TIMER);
    meas(0, w);
    chk_cnt(w, SYNC_SHORT_CYC);
    cmd(0, OP_TRIG_SRC, SRC_NONE);
    chk(16'(SYNC_SUPPLY_EN), 16'h2);
    $display("test trigger sources done");
    watch = 1;
    partner_u.send(0, 10'h0b5);
    repeat (20) @(negedge CLOCK);
    chk(16'(FRAME_VALID), 16'h1);
    chk(16'(FRAME_OVERRUN), 16'h0);
    chk(16'(FRAME_DATA[0]), 16'h0b5);
    // first frame left unread on purpose, so the newer one overwrites and flags it
    partner_u.send(0, 10'h12c);
    repeat (20) @(negedge CLOCK);
    chk(16'(FRAME_VALID), 16'h1);
    chk(16'(FRAME_OVERRUN), 16'h1);
    chk(16'(FRAME_DATA[0]), 16'h12c);
    FRAME_READ[0] = 1;
    @(negedge CLOCK);
    FRAME_READ[0] = 0;
    @(negedge CLOCK);
    chk(16'(FRAME_VALID), 16'h0);
    chk(16'(FRAME_OVERRUN), 16'h0);
    MODE_SEL = 1;
    repeat (4) @(negedge CLOCK);
    partner_u.send(0, 10'h16a);
    repeat (20) @(negedge CLOCK);
    watch = 0;
    chk(16'(FRAME_VALID), 16'h0);
    cmd(1, OP_ENABLE, 2'h0);
    chk(16'(CHAN_ACTIVE), 16'h1);
    chk(16'(SYNC_SUPPLY_EN), 16'h0);
    $display("test frames done");
    final_report();
  end
endmodule
